// ### common/jri_pkg.sv
// constants, state codes and sync-vector layout for the jtag ram init loader
// assumes a 100 mhz ref_clk and a tap bridge whose outputs are asynchronous to it
package jri_pkg;

  // instruction codes available to user logic
  localparam logic [7:0] USER_CODE_MIN = 8'h10;
  localparam logic [7:0] USER_CODE_MAX = 8'h7f;
  // loading and read-back opcodes
  localparam logic [7:0] CODE_LOAD_START = 8'h22;
  localparam logic [7:0] CODE_LOAD_STOP = 8'h23;
  localparam logic [7:0] CODE_READ_TEST = 8'h23;
  localparam int INSTR_W = 8;

  // clock and write-strobe timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WR_SETUP_NS = 40;
  localparam int WR_HOLD_NS = 40;
  // least times, rounded up to whole cycles
  localparam int WR_SETUP_CYC = (WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_HOLD_CYC = (WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // bit positions in the synchronised input vector
  localparam int SY_DRCK = 0;
  localparam int SY_SHIFT = 1;
  localparam int SY_UPD = 2;
  localparam int SY_SER = 3;
  localparam int SY_TRST_N = 4;
  localparam int SY_TEST = 5;
  localparam int SY_TCLK = 6;
  localparam int SY_INSTR = 7;
  localparam int SY_RDATA = SY_INSTR + INSTR_W;

  // write strobe sequencer
  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_SETUP = 2'b01,
    W_HOLD = 2'b10
  } jri_wstate_type;

endpackage : jri_pkg

// ### core/jri_loader.sv
// jtag ram initialisation loader: tap bridge in, ram write/read ports out, fifo between
// assumes all bridge and test inputs are asynchronous to ref_clk and far slower than it
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - start and read-back opcodes must lie in the user range sixteen to one hundred twenty-seven.
// - opcode thirty-four starts loading, thirty-five ends it; host loads them.
// - a chip select per memory picks the block being loaded, via ring counter.
// - serial bridge data is gathered and presented as a parallel write word.
// - the block makes the ram write clock; data, address, select follow it.
// - the collecting shift register is exactly one ram word wide.
// - the collecting register advances on the bridge data-register clock.
// - a full word passes through a pipeline register before reaching the ram.
// - the write address comes from an internal counter sweeping the range.
// - with identical contents one shared enable writes all blocks together.
// - after a block's last address the ring counter steps to the next block.
// - shifting happens only while the bridge shift flag is high.
// - the write address and write enables act only while the start opcode is held.
// - a high update flag marks completion of one loaded word.
// - on update rising the word is queued; new data and the next address appear when the fifo pops it.
// - write clock is low while data settles, rising afterwards to write.
// - for falling-edge rams the write clock runs inverted, idling low.
// - default build loads a four by four ram and offers read-back test.
// - the clock output writes during loading and reads during read-back.
// - loading enabled while code is hex 22; active-low write enable inverts it.
// - read-back needs test high and code hex 23; read enable low, test clock steps address.

// rising-edge finder on a synchronised level and its one-cycle-older copy
module jri_rise_det (
  input wire logic cur,
  input wire logic prev,
  output logic rise
);
  assign rise = cur && !prev;
endmodule : jri_rise_det

module jri_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  input wire logic flush
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least two");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("fifo width must be at least one");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0] wptr;
    logic [PW:0] rptr;
  } jri_fifo_state_type;

  jri_fifo_state_type st_reg;
  jri_fifo_state_type st_next;
  logic empty;
  logic full;

  // full and empty from pointers with one wrap bit
  assign empty = st_reg.wptr == st_reg.rptr;
  assign full = (st_reg.wptr[PW-1:0] == st_reg.rptr[PW-1:0]) &&
                (st_reg.wptr[PW] != st_reg.rptr[PW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_reg.mem[st_reg.rptr[PW-1:0]];

  always_comb begin
    st_next = st_reg;
    if (in_valid && !full) begin
      st_next.mem[st_reg.wptr[PW-1:0]] = in_data;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    if (flush) begin
      st_next.wptr = '0;
      st_next.rptr = '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : jri_fifo

module jri_loader #(
  parameter int DATA_W = 4,
  parameter int ADDR_W = 2,
  parameter int NUM_BLOCKS = 1,
  parameter bit SHARED_WE = 1'b0,
  parameter bit FALLING_EDGE_RAM = 1'b0,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [jri_pkg::INSTR_W-1:0] bridge_instruction_value,
  input wire logic bridge_dr_clock,
  input wire logic bridge_dr_shift_flag,
  input wire logic bridge_dr_update_flag,
  input wire logic bridge_serial_data_out,
  input wire logic bridge_tap_reset_n,
  input wire logic test_mode,
  input wire logic test_clk,
  input wire logic [DATA_W-1:0] ram_read_word,
  input wire logic ram_ready,
  output logic [DATA_W-1:0] ram_write_word,
  output logic [ADDR_W-1:0] ram_write_addr,
  output logic [ADDR_W-1:0] ram_read_addr,
  output logic [NUM_BLOCKS-1:0] ram_chip_select,
  output logic ram_wr_en_n,
  output logic ram_rd_en_n,
  output logic ram_clk,
  output logic [DATA_W-1:0] test_out,
  output logic fifo_in_ready,
  output logic load_overrun
);
  localparam int SW = jri_pkg::SY_RDATA + DATA_W;
  localparam logic [ADDR_W-1:0] ADDR_LAST = '1;
  localparam logic [NUM_BLOCKS-1:0] RING_FIRST = NUM_BLOCKS'(1);
  localparam logic WCLK_IDLE = !FALLING_EDGE_RAM;
  localparam logic [jri_pkg::CNT_W-1:0] SETUP_LOAD = jri_pkg::CNT_W'(jri_pkg::WR_SETUP_CYC - 1);
  localparam logic [jri_pkg::CNT_W-1:0] HOLD_LOAD = jri_pkg::CNT_W'(jri_pkg::WR_HOLD_CYC - 1);

  if (DATA_W < 1 || ADDR_W < 1 || NUM_BLOCKS < 1) begin : g_bad_size
    $error("data width, address width and block count must be positive");
  end
  // the phase counter loads cycles minus one, so zero cycles would wrap it
  if (jri_pkg::WR_SETUP_CYC < 1 ||
      jri_pkg::WR_SETUP_CYC > (1 << jri_pkg::CNT_W) ||
      jri_pkg::WR_HOLD_CYC < 1 ||
      jri_pkg::WR_HOLD_CYC > (1 << jri_pkg::CNT_W)) begin : g_bad_cnt
    $error("write strobe phases do not fit the phase counter");
  end
  // opcodes outside the user range would collide with reserved tap instructions
  if (jri_pkg::CODE_LOAD_START < jri_pkg::USER_CODE_MIN ||
      jri_pkg::CODE_LOAD_START > jri_pkg::USER_CODE_MAX ||
      jri_pkg::CODE_READ_TEST < jri_pkg::USER_CODE_MIN ||
      jri_pkg::CODE_READ_TEST > jri_pkg::USER_CODE_MAX) begin : g_bad_code
    $error("loader opcodes must be user instruction codes");
  end

  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    logic [DATA_W-1:0] shreg;
    logic [DATA_W-1:0] wword;
    logic [ADDR_W-1:0] waddr;
    logic [ADDR_W-1:0] raddr;
    logic [NUM_BLOCKS-1:0] ring;
    jri_pkg::jri_wstate_type wst;
    logic [jri_pkg::CNT_W-1:0] cnt;
    logic wclk;
    logic clk_out;
    logic [DATA_W-1:0] tout;
    logic overrun;
  } jri_loader_state_type;

  jri_loader_state_type st_reg;
  jri_loader_state_type st_next;
  logic [SW-1:0] in_vec;
  logic [jri_pkg::INSTR_W-1:0] instr;
  logic load_enable;
  logic test_active;
  logic drck_rise;
  logic upd_rise;
  logic tclk_rise;
  logic tap_reset;
  logic push;
  logic pop;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  // every input from the tap or the test pins crosses on two flops first
  assign in_vec = {ram_read_word, bridge_instruction_value, test_clk, test_mode,
                   bridge_tap_reset_n, bridge_serial_data_out, bridge_dr_update_flag,
                   bridge_dr_shift_flag, bridge_dr_clock};

  // the instruction value is quasi-static across a scan, so per-bit sync is enough
  assign instr = st_reg.s2[jri_pkg::SY_INSTR +: jri_pkg::INSTR_W];
  assign load_enable = instr == jri_pkg::CODE_LOAD_START;
  assign test_active = st_reg.s2[jri_pkg::SY_TEST] &&
                       (instr == jri_pkg::CODE_READ_TEST);
  // edges are taken one stage past the synchroniser, never from the first flop
  jri_rise_det u_drck_rise (
    .cur(st_reg.s2[jri_pkg::SY_DRCK]),
    .prev(st_reg.s3[jri_pkg::SY_DRCK]),
    .rise(drck_rise)
  );
  jri_rise_det u_upd_rise (
    .cur(st_reg.s2[jri_pkg::SY_UPD]),
    .prev(st_reg.s3[jri_pkg::SY_UPD]),
    .rise(upd_rise)
  );
  jri_rise_det u_tclk_rise (
    .cur(st_reg.s2[jri_pkg::SY_TCLK]),
    .prev(st_reg.s3[jri_pkg::SY_TCLK]),
    .rise(tclk_rise)
  );
  assign tap_reset = !st_reg.s2[jri_pkg::SY_TRST_N];

  // a finished word enters the fifo only while loading is enabled
  assign push = upd_rise && load_enable;
  assign pop = (st_reg.wst == jri_pkg::W_IDLE) && fifo_out_valid && ram_ready && load_enable;

  jri_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.shreg),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .flush(tap_reset)
  );

  always_comb begin
    st_next = st_reg;
    st_next.s1 = in_vec;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;

    // lsb-first serial collection, one word wide
    if (drck_rise && st_reg.s2[jri_pkg::SY_SHIFT]) begin
      st_next.shreg = {st_reg.s2[jri_pkg::SY_SER], st_reg.shreg[DATA_W-1:1]};
    end

    // a word lost to a full fifo is flagged; the tap cannot be stalled
    // a loss in the same cycle as a tap reset wins, so it is never hidden
    if (push && !fifo_in_ready) begin
      st_next.overrun = 1'b1;
    end else if (tap_reset) begin
      st_next.overrun = 1'b0;
    end

    // write strobe: low phase while data settles, rising edge writes
    case (st_reg.wst)
      jri_pkg::W_IDLE: begin
        st_next.wclk = WCLK_IDLE;
        if (pop) begin
          st_next.wword = fifo_out_data;
          st_next.waddr = st_reg.waddr + 1'b1;
          st_next.wclk = !WCLK_IDLE;
          st_next.cnt = SETUP_LOAD;
          st_next.wst = jri_pkg::W_SETUP;
        end
      end
      jri_pkg::W_SETUP: begin
        if (st_reg.cnt == '0) begin
          st_next.wclk = WCLK_IDLE;
          st_next.cnt = HOLD_LOAD;
          st_next.wst = jri_pkg::W_HOLD;
        end else begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end
      end
      jri_pkg::W_HOLD: begin
        if (st_reg.cnt == '0) begin
          // one ring step after the last address of the current block
          if (st_reg.waddr == ADDR_LAST && NUM_BLOCKS > 1) begin
            // shift form keeps a one-block build free of a reversed part-select
            st_next.ring = (st_reg.ring << 1) | (st_reg.ring >> (NUM_BLOCKS - 1));
          end
          st_next.wst = jri_pkg::W_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end
      end
      default: begin
        st_next.wst = jri_pkg::W_IDLE;
        st_next.wclk = WCLK_IDLE;
      end
    endcase

    // read-back: the test clock steps the read address
    if (tclk_rise && test_active) begin
      st_next.raddr = st_reg.raddr + 1'b1;
    end
    st_next.tout = st_reg.s2[jri_pkg::SY_RDATA +: DATA_W];

    // one clock pin serves both directions of the ram
    st_next.clk_out = test_active ? st_reg.s2[jri_pkg::SY_TCLK] : st_next.wclk;

    if (tap_reset) begin
      st_next.waddr = '1;
      st_next.raddr = '1;
      st_next.ring = RING_FIRST;
      st_next.shreg = '0;
      st_next.wst = jri_pkg::W_IDLE;
      st_next.wclk = WCLK_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.waddr <= '1;
      st_reg.raddr <= '1;
      st_reg.ring <= RING_FIRST;
      st_reg.wclk <= WCLK_IDLE;
      st_reg.clk_out <= WCLK_IDLE;
      st_reg.wst <= jri_pkg::W_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ram_write_word = st_reg.wword;
  assign ram_write_addr = st_reg.waddr;
  assign ram_read_addr = st_reg.raddr;
  assign ram_clk = st_reg.clk_out;
  assign test_out = st_reg.tout;
  assign load_overrun = st_reg.overrun;
  // shared enable writes every block at once when contents match
  assign ram_chip_select = !load_enable ? '0 : (SHARED_WE ? '1 : st_reg.ring);
  assign ram_wr_en_n = !load_enable;
  assign ram_rd_en_n = !test_active;

endmodule : jri_loader

`default_nettype wire

// ### verification/jri_loader_monitor.sv
// checker for the loader's ram-side outputs, default build
// assumes rising-edge rams and a bind onto every jri_loader
`timescale 1ns/1ns
`default_nettype none
module jri_loader_monitor #(
  parameter int DATA_W = 4,
  parameter int ADDR_W = 2,
  parameter int NUM_BLOCKS = 1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] bridge_instruction_value,
  input wire logic test_mode,
  input wire logic [DATA_W-1:0] ram_write_word,
  input wire logic [ADDR_W-1:0] ram_write_addr,
  input wire logic [ADDR_W-1:0] ram_read_addr,
  input wire logic [NUM_BLOCKS-1:0] ram_chip_select,
  input wire logic ram_wr_en_n,
  input wire logic ram_rd_en_n,
  input wire logic ram_clk
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // five samples cover the two-flop sync; the enables are decoded from it without a register
  sequence s_low;
    !ram_clk [*4];
  endsequence
  sequence s_hold;
    $stable(ram_write_word) [*4];
  endsequence
  property p_wr_on;
    (bridge_instruction_value == 8'h22) [*5] |-> !ram_wr_en_n;
  endproperty
  property p_wr_off;
    (bridge_instruction_value != 8'h22) [*5] |-> ram_wr_en_n;
  endproperty
  property p_cs_gate;
    (ram_wr_en_n |-> ram_chip_select == '0) and
    (!ram_wr_en_n |-> ram_chip_select != '0);
  endproperty
  property p_rd_on;
    (test_mode && bridge_instruction_value == 8'h23) [*5] |-> !ram_rd_en_n;
  endproperty
  property p_strobe;
    $fell(ram_clk) && ram_rd_en_n |-> s_low ##1 ram_clk;
  endproperty
  property p_hold;
    $rose(ram_clk) && ram_rd_en_n |-> ##1 s_hold;
  endproperty
  property p_addr_step;
    $fell(ram_clk) && ram_rd_en_n |->
      ram_write_addr == ADDR_W'($past(ram_write_addr) + 1);
  endproperty
  // a tap reset presets to all ones without a strobe
  property p_pop_only;
    $changed(ram_write_addr) && ram_write_addr != '1 |-> $fell(ram_clk);
  endproperty
  property p_raddr;
    $changed(ram_read_addr) |->
      !ram_rd_en_n && ram_read_addr == ADDR_W'($past(ram_read_addr) + 1);
  endproperty
  a_wr_on: assert property (p_wr_on) else $error("write enable not low");
  a_wr_off: assert property (p_wr_off) else $error("write enable not high");
  a_cs_gate: assert property (p_cs_gate) else $error("select while idle");
  a_rd_on: assert property (p_rd_on) else $error("read enable not low");
  a_strobe: assert property (p_strobe) else $error("strobe length wrong");
  a_hold: assert property (p_hold) else $error("word moved in hold");
  a_addr_step: assert property (p_addr_step) else $error("address step wrong");
  a_pop_only: assert property (p_pop_only) else $error("address moved alone");
  a_raddr: assert property (p_raddr) else $error("read address wrong");
endmodule : jri_loader_monitor
bind jri_loader jri_loader_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W),
  .NUM_BLOCKS(NUM_BLOCKS)) u_mon (.ref_clk(ref_clk), .arst_n(arst_n),
  .bridge_instruction_value(bridge_instruction_value), .test_mode(test_mode),
  .ram_write_word(ram_write_word), .ram_write_addr(ram_write_addr),
  .ram_read_addr(ram_read_addr), .ram_chip_select(ram_chip_select),
  .ram_wr_en_n(ram_wr_en_n), .ram_rd_en_n(ram_rd_en_n), .ram_clk(ram_clk));
`default_nettype wire

// ### verification/jri_tap_model.sv
// tap bridge model: drives instruction, scan and update pins like a host
// assumes its tasks are called one at a time; link clock period 125 ns
`timescale 1ns/1ns
`default_nettype none
module jri_tap_model (
  output logic [7:0] instr,
  output logic drck,
  output logic shift,
  output logic upd,
  output logic ser,
  output logic trst_n
);
  initial begin
    instr = 8'h00;
    drck = 1'b0;
    shift = 1'b0;
    upd = 1'b0;
    ser = 1'b0;
    trst_n = 1'b1;
  end
  task automatic set_code(input logic [7:0] code);
    instr = code;
    #250;
  endtask : set_code
  task automatic tap_reset();
    trst_n = 1'b0;
    #250;
    trst_n = 1'b1;
    #250;
  endtask : tap_reset
  // clock stands still between scans; a released data line shows the inverse
  task automatic scan(input logic [3:0] w, input int extra);
    for (int i = 0; i < 4 + extra; i++) begin
      shift = (i < 4);
      ser = (i < 4) ? w[i] : ~ser;
      #62;
      drck = 1'b1;
      #63;
      drck = 1'b0;
    end
    shift = 1'b0;
    ser = ~ser;
    #125;
    upd = 1'b1;
    #250;
    upd = 1'b0;
    #250;
  endtask : scan
endmodule : jri_tap_model
`default_nettype wire

// ### verification/jri_loader_bench.sv
// self-checking bench: load, refusal, shift gating, fifo stall, read-back
// assumes jri_tap_model on the bridge pins and a 100 mhz ref_clk
`timescale 1ns/1ns
`default_nettype none
module jri_loader_bench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic test_mode = 1'b0;
  logic test_clk = 1'b0;
  logic ram_ready = 1'b1;
  logic [3:0] rword = 4'h6;
  logic [7:0] instr;
  logic drck, shift, upd, ser, trst_n;
  logic [3:0] wword, tout;
  logic [1:0] waddr, raddr;
  logic [0:0] cs;
  logic wen_n, ren_n, rclk, fin_rdy, ovr;
  int err_count = 0;
  int total_checks = 0;
  int wr_count = 0;
  logic [1:0] exp_addr = 2'h3;
  logic [3:0] exp_word = 4'h0;
  always #5 ref_clk = ~ref_clk;
  always @(negedge rclk) wr_count++;
  jri_tap_model TAP (.instr(instr), .drck(drck), .shift(shift), .upd(upd),
    .ser(ser), .trst_n(trst_n));
  jri_loader DUT (.ref_clk(ref_clk), .arst_n(arst_n), .bridge_instruction_value(instr),
    .bridge_dr_clock(drck), .bridge_dr_shift_flag(shift), .bridge_dr_update_flag(upd),
    .bridge_serial_data_out(ser), .bridge_tap_reset_n(trst_n), .test_mode(test_mode),
    .test_clk(test_clk), .ram_read_word(rword), .ram_ready(ram_ready),
    .ram_write_word(wword), .ram_write_addr(waddr), .ram_read_addr(raddr),
    .ram_chip_select(cs), .ram_wr_en_n(wen_n), .ram_rd_en_n(ren_n), .ram_clk(rclk),
    .test_out(tout), .fifo_in_ready(fin_rdy), .load_overrun(ovr));
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_out(input logic en_n, input logic [0:0] sel);
    chk("word", exp_word, wword);
    chk("addr", {2'h0, exp_addr}, {2'h0, waddr});
    chk("wen_n", {3'h0, en_n}, {3'h0, wen_n});
    chk("cs", {3'h0, sel}, {3'h0, cs});
  endtask : chk_out
  task automatic t_load();
    TAP.set_code(jri_pkg::CODE_LOAD_START);
    TAP.tap_reset();
    for (int i = 0; i < 4; i++) begin
      exp_word = 4'(5 * i + 3);
      TAP.scan(exp_word, 0);
      exp_addr++;
      chk_out(1'b0, 1'b1);
    end
  endtask : t_load
  task automatic t_refuse();
    TAP.set_code(8'h30);
    TAP.scan(4'h9, 0);
    chk_out(1'b1, 1'b0);
  endtask : t_refuse
  task automatic t_gate();
    TAP.set_code(jri_pkg::CODE_LOAD_START);
    exp_word = 4'ha;
    TAP.scan(exp_word, 3);
    exp_addr++;
    chk_out(1'b0, 1'b1);
  endtask : t_gate
  task automatic t_fifo();
    int n;
    @(posedge ref_clk);
    ram_ready <= 1'b0;
    for (int i = 0; i < 17; i++)
      TAP.scan(4'(i), 0);
    chk_out(1'b0, 1'b1);
    chk("fifo_rdy", 4'h0, {3'h0, fin_rdy});
    chk("ovr", 4'h1, {3'h0, ovr});
    n = wr_count;
    @(posedge ref_clk);
    ram_ready <= 1'b1;
    for (int k = 0; k < 600 && wr_count - n < 16; k++)
      @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    exp_word = 4'hf;
    chk("writes", 4'h0, 4'(wr_count - n - 16));
    chk_out(1'b0, 1'b1);
    chk("fifo_rdy", 4'h1, {3'h0, fin_rdy});
    TAP.tap_reset();
    chk("ovr", 4'h0, {3'h0, ovr});
  endtask : t_fifo
  task automatic t_read();
    TAP.set_code(jri_pkg::CODE_READ_TEST);
    chk("wen_n", 4'h1, {3'h0, wen_n});
    chk("ren_n", 4'h1, {3'h0, ren_n});
    @(posedge ref_clk);
    test_mode <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("ren_n", 4'h0, {3'h0, ren_n});
    for (int i = 0; i < 4; i++) begin
      rword <= 4'(i + 9);
      test_clk <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk("raddr", 4'(i), {2'h0, raddr});
      chk("rclk", 4'h1, {3'h0, rclk});
      chk("tout", 4'(i + 9), tout);
      test_clk <= 1'b0;
      repeat (7) @(posedge ref_clk);
    end
    test_mode <= 1'b0;
  endtask : t_read
  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_load();
    t_refuse();
    t_gate();
    t_fifo();
    t_read();
    print_verdict();
  end
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule : jri_loader_bench
`default_nettype wire
